// [mpf_pkg.sv]
// Package with constants, register map and carrier types of the pause flow-control unit.
package mpf_pkg;
  localparam int unsigned CLK_PERIOD_NS = 25;
  localparam int unsigned SLOT_TIME_NS = 512;
  localparam int unsigned SLOT_CYCLES = (SLOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned WM_BITS = 13;
  localparam logic [15:0] PAUSE_OPCODE = 16'h0001;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PADDR_LO = 8'h04;
  localparam logic [7:0] ADDR_PADDR_HI = 8'h08;
  localparam logic [7:0] ADDR_CTL_TYPE = 8'h0c;
  localparam logic [7:0] ADDR_TX_TIME = 8'h10;
  localparam logic [7:0] ADDR_HIGH_WM = 8'h14;
  localparam logic [7:0] ADDR_LOW_WM = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_XON_CNT = 8'h20;
  localparam logic [7:0] ADDR_XOFF_CNT = 8'h24;
  localparam int unsigned CTRL_RX_PAUSE_EN = 0;
  localparam int unsigned CTRL_TX_PAUSE_EN = 1;
  localparam int unsigned CTRL_DROP_PAUSE = 2;
  localparam int unsigned CTRL_FWD_CTL = 3;
  localparam int unsigned CTRL_XON_SEND_EN = 4;
  localparam int unsigned CTRL_EXT_PAUSE_EN = 5;
  localparam int unsigned CTRL_SW_PAUSE_REQ = 6;
  localparam int unsigned CTRL_HALT_NOW = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [15:0] CTL_TYPE_RESET = 16'h0000;
  localparam logic [15:0] TX_TIME_RESET = 16'h0000;
  localparam logic [47:0] PADDR_RESET = 48'h0000_0000_0000;
  localparam int unsigned ST_PAUSED = 0;
  localparam int unsigned ST_ABOVE = 1;
  localparam int unsigned ST_BELOW = 2;
  localparam int unsigned ST_TIMER_LSB = 16;
  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;

  typedef struct packed {
    logic eof;
    logic fcs_ok;
    logic [47:0] dest;
    logic [15:0] etype;
    logic [15:0] opcode;
    logic [15:0] ptime;
  } mpf_rx_frame_t;

  typedef struct packed {
    logic req;
    logic [15:0] ptime;
  } mpf_tx_pause_t;

  typedef struct packed {
    logic decide;
    logic drop;
  } mpf_rx_verdict_t;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b01,
    TX_SEND = 2'b10
  } mpf_tx_state_t;
endpackage

// [mpf_flow_ctrl.sv]
// Pause flow-control unit: control-frame check, pause timer, pause frame requests, AHB-Lite regs.
//
// Decided for this implementation: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module mpf_flow_ctrl #(
  parameter int unsigned WM_W = mpf_pkg::WM_BITS,
  parameter int unsigned SLOT_CNT = mpf_pkg::SLOT_CYCLES
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic [47:0] STATION_ADDR,
  input wire mpf_pkg::mpf_rx_frame_t RX_FRAME,
  output mpf_pkg::mpf_rx_verdict_t RX_VERDICT,
  output logic XOFF_RX_EVENT,
  input wire logic TX_BUSY,
  output logic TX_HOLD,
  output mpf_pkg::mpf_tx_pause_t TX_PAUSE,
  input wire logic TX_PAUSE_DONE,
  input wire logic [WM_W-1:0] RX_FILL,
  input wire logic RX_OVERFLOW,
  input wire logic EXT_XOFF,
  input wire logic EXT_RESUME,
  output logic ABOVE_HIGH,
  output logic BELOW_LOW
);
  import mpf_pkg::*;

  initial begin
    if (WM_W != WM_BITS || SLOT_CNT < 1 || SLOT_CNT > 255) begin
      $error("mpf_flow_ctrl: unsupported watermark width or slot count");
    end
  end

  // Register file.
  logic [7:0] ctrl_reg;
  logic [47:0] paddr_reg;
  logic [15:0] ctl_type_reg;
  logic [15:0] tx_time_reg;
  logic [WM_W-1:0] high_wm_reg;
  logic [WM_W-1:0] low_wm_reg;
  logic [31:0] xon_rx_counter_reg;
  logic [31:0] xoff_rx_counter_reg;

  // Bus slave state.
  logic wr_pend_reg;
  logic [7:0] wr_addr_reg;
  logic [31:0] rdata_reg;

  // Flow-control state.
  logic tx_paused_flag_reg;
  logic [15:0] timer_reg;
  logic [7:0] slot_cnt_reg;
  logic slot_tick_reg;
  logic hold_reg;
  logic xoff_evt_reg;
  logic decide_reg;
  logic drop_reg;
  logic auto_sent_reg;
  logic extra_sent_reg;
  logic pend_xoff_reg;
  logic pend_xon_reg;
  logic pend_sw_reg;
  logic inflight_sw_reg;
  mpf_tx_state_t tx_state_reg;
  logic [15:0] tx_ptime_reg;
  logic tx_req_reg;
  logic above_reg;
  logic below_reg;
  logic ext_armed_reg;
  logic [2:0] xoff_sync_reg;
  logic [2:0] resume_sync_reg;

  // Zero-extends a watermark to a full bus word.
  function automatic logic [31:0] wm_word(input logic [WM_W-1:0] v);
    wm_word = {{(32 - WM_W){1'b0}}, v};
  endfunction

  // Address phase and data phase decode.
  wire addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
  wire wr_take = addr_take && HWRITE;
  wire rd_take = addr_take && !HWRITE;
  wire [7:0] a_addr = HADDR[7:0];
  wire a_hit = (HADDR[31:8] == 24'h00_0000);
  wire wr_ctrl = wr_pend_reg && (wr_addr_reg == ADDR_CTRL);
  // A one written to the request bit starts a software pause frame.
  wire sw_set = wr_ctrl && HWDATA[CTRL_SW_PAUSE_REQ];

  // Read data is registered at the address phase and stands until the next read.
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (a_hit) begin
      case (a_addr)
        ADDR_CTRL: rd_mux = {24'h00_0000, ctrl_reg};
        ADDR_PADDR_LO: rd_mux = paddr_reg[31:0];
        ADDR_PADDR_HI: rd_mux = {16'h0000, paddr_reg[47:32]};
        ADDR_CTL_TYPE: rd_mux = {16'h0000, ctl_type_reg};
        ADDR_TX_TIME: rd_mux = {16'h0000, tx_time_reg};
        ADDR_HIGH_WM: rd_mux = wm_word(high_wm_reg);
        ADDR_LOW_WM: rd_mux = wm_word(low_wm_reg);
        ADDR_STATUS: rd_mux = {timer_reg, 13'h0000, below_reg, above_reg, tx_paused_flag_reg};
        ADDR_XON_CNT: rd_mux = xon_rx_counter_reg;
        ADDR_XOFF_CNT: rd_mux = xoff_rx_counter_reg;
        default: rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // Receive frame classification, only on a good frame end.
  wire rx_good = RX_FRAME.eof && RX_FRAME.fcs_ok;
  wire da_station = (RX_FRAME.dest == STATION_ADDR);
  wire da_match = (RX_FRAME.dest == paddr_reg) || da_station;
  wire ctl_match = rx_good && da_match && (RX_FRAME.etype == ctl_type_reg);
  wire is_pause = ctl_match && (RX_FRAME.opcode == PAUSE_OPCODE);
  wire act_pause = is_pause && ctrl_reg[CTRL_RX_PAUSE_EN];
  wire rx_xoff = act_pause && (RX_FRAME.ptime != 16'h0000);
  wire rx_xon = act_pause && (RX_FRAME.ptime == 16'h0000);
  // Non-pause control frames reach the host only with the forward bit set.
  wire drop_next = is_pause ? (ctrl_reg[CTRL_DROP_PAUSE] && da_station)
                            : !ctrl_reg[CTRL_FWD_CTL];
  // The slot tick that takes a running timer from one to zero ends the pause.
  wire timer_expire = slot_tick_reg && (timer_reg == 16'h0001);

  // Transmit request sources.
  wire tx_en = ctrl_reg[CTRL_TX_PAUSE_EN];
  wire xon_en = ctrl_reg[CTRL_XON_SEND_EN];
  wire ext_en = ctrl_reg[CTRL_EXT_PAUSE_EN] && tx_en;
  wire above_next = (RX_FILL >= high_wm_reg);
  wire below_next = (RX_FILL <= low_wm_reg);
  wire auto_xoff = tx_en && above_next && !auto_sent_reg;
  wire auto_extra = tx_en && auto_sent_reg && !extra_sent_reg && RX_OVERFLOW;
  wire auto_xon = tx_en && auto_sent_reg && below_next;
  wire ext_xoff_hi = xoff_sync_reg[1];
  wire ext_res_rise = resume_sync_reg[1] && !resume_sync_reg[2];
  wire ext_xoff = ext_en && ext_armed_reg && ext_xoff_hi;
  wire ext_xon = ext_en && ext_res_rise && !ext_xoff_hi && xon_en;
  // An XOFF from any source outranks a waiting XON.
  wire want_xoff = auto_xoff || auto_extra || ext_xoff;
  wire want_xon = (auto_xon && xon_en) || ext_xon;
  // The sender takes one request at a time, the software request first.
  wire tx_start = (tx_state_reg == TX_IDLE) && (pend_xoff_reg || pend_xon_reg || pend_sw_reg);
  wire tx_done = (tx_state_reg == TX_SEND) && TX_PAUSE_DONE;
  wire start_xon = !pend_xoff_reg && !pend_sw_reg;
  wire sw_done = tx_done && inflight_sw_reg && !pend_sw_reg;

  mpf_tx_state_t tx_state_next;
  always_comb begin
    case (tx_state_reg)
      TX_IDLE: tx_state_next = tx_start ? TX_SEND : TX_IDLE;
      TX_SEND: tx_state_next = TX_PAUSE_DONE ? TX_IDLE : TX_SEND;
      default: tx_state_next = TX_IDLE;
    endcase
  end

  // Bus slave.
  // A write lands at the end of its data phase, while HWDATA stands.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      rdata_reg <= 32'h0000_0000;
    end else begin
      wr_pend_reg <= wr_take && a_hit;
      wr_addr_reg <= a_addr;
      if (rd_take) begin
        rdata_reg <= rd_mux;
      end
    end
  end

  // Software-written registers.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl_reg <= CTRL_RESET;
      paddr_reg <= PADDR_RESET;
      ctl_type_reg <= CTL_TYPE_RESET;
      tx_time_reg <= TX_TIME_RESET;
      high_wm_reg <= '0;
      low_wm_reg <= '0;
    end else begin
      if (wr_ctrl) begin
        ctrl_reg <= HWDATA[7:0];
      end
      // A write of zero cannot withdraw a software request that is still outstanding.
      if (sw_set || (wr_ctrl && ctrl_reg[CTRL_SW_PAUSE_REQ] && !sw_done)) begin
        ctrl_reg[CTRL_SW_PAUSE_REQ] <= 1'b1;
      end else if (sw_done) begin
        ctrl_reg[CTRL_SW_PAUSE_REQ] <= 1'b0;
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_PADDR_LO) begin
        paddr_reg[31:0] <= HWDATA;
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_PADDR_HI) begin
        paddr_reg[47:32] <= HWDATA[15:0];
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_CTL_TYPE) begin
        ctl_type_reg <= HWDATA[15:0];
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_TX_TIME) begin
        tx_time_reg <= HWDATA[15:0];
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_HIGH_WM) begin
        high_wm_reg <= HWDATA[WM_W-1:0];
      end
      if (wr_pend_reg && wr_addr_reg == ADDR_LOW_WM) begin
        low_wm_reg <= HWDATA[WM_W-1:0];
      end
    end
  end

  // Slot-time divider.
  // One tick every SLOT_CNT cycles stands for one slot time.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      slot_cnt_reg <= 8'h00;
      slot_tick_reg <= 1'b0;
    end else begin
      slot_tick_reg <= (slot_cnt_reg == 8'(SLOT_CNT - 1));
      slot_cnt_reg <= (slot_cnt_reg == 8'(SLOT_CNT - 1)) ? 8'h00 : slot_cnt_reg + 8'h01;
    end
  end

  // Pause timer, paused flag, transmit hold and receive counters.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      timer_reg <= 16'h0000;
      tx_paused_flag_reg <= 1'b0;
      hold_reg <= 1'b0;
      xoff_evt_reg <= 1'b0;
      xon_rx_counter_reg <= 32'h0000_0000;
      xoff_rx_counter_reg <= 32'h0000_0000;
      decide_reg <= 1'b0;
      drop_reg <= 1'b0;
    end else begin
      xoff_evt_reg <= rx_xoff;
      decide_reg <= ctl_match;
      drop_reg <= ctl_match && drop_next;
      if (rx_xoff) begin
        timer_reg <= RX_FRAME.ptime;
        tx_paused_flag_reg <= 1'b1;
        xoff_rx_counter_reg <= xoff_rx_counter_reg + 32'h0000_0001;
      end else if (rx_xon) begin
        timer_reg <= 16'h0000;
        tx_paused_flag_reg <= 1'b0;
        xon_rx_counter_reg <= xon_rx_counter_reg + 32'h0000_0001;
      end else if (slot_tick_reg && timer_reg != 16'h0000) begin
        timer_reg <= timer_reg - 16'h0001;
        if (timer_expire) begin
          tx_paused_flag_reg <= 1'b0;
        end
      end
      // Halt at once, or only once the frame in progress has gone out.
      hold_reg <= tx_paused_flag_reg &&
                  (hold_reg || ctrl_reg[CTRL_HALT_NOW] || !TX_BUSY);
    end
  end

  // Pin synchronisers and watermark flags.
  // Only the second stage of the XOFF synchroniser feeds logic; the resume edge detect uses its second and third stages.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      xoff_sync_reg <= 3'h0;
      resume_sync_reg <= 3'h0;
      above_reg <= 1'b0;
      below_reg <= 1'b0;
    end else begin
      xoff_sync_reg <= {xoff_sync_reg[1:0], EXT_XOFF};
      resume_sync_reg <= {resume_sync_reg[1:0], EXT_RESUME};
      above_reg <= above_next;
      below_reg <= below_next;
    end
  end

  // Request bookkeeping and the pause frame sender.
  always_ff @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      auto_sent_reg <= 1'b0;
      extra_sent_reg <= 1'b0;
      ext_armed_reg <= 1'b1;
      pend_xoff_reg <= 1'b0;
      pend_xon_reg <= 1'b0;
      pend_sw_reg <= 1'b0;
      inflight_sw_reg <= 1'b0;
      tx_state_reg <= TX_IDLE;
      tx_ptime_reg <= 16'h0000;
      tx_req_reg <= 1'b0;
    end else begin
      tx_state_reg <= tx_state_next;
      // The request output is a flop loaded from the next sender state.
      tx_req_reg <= (tx_state_next == TX_SEND);
      // Automatic XOFF re-arms only once fullness has fallen to the low watermark.
      if (auto_xoff) begin
        auto_sent_reg <= 1'b1;
        extra_sent_reg <= 1'b0;
      end else if (auto_xon) begin
        auto_sent_reg <= 1'b0;
      end
      if (auto_extra) begin
        extra_sent_reg <= 1'b1;
      end
      // A resume edge while the XOFF pin is low re-arms the pin trigger.
      if (ext_xoff) begin
        ext_armed_reg <= 1'b0;
      end else if (ext_res_rise && !ext_xoff_hi) begin
        ext_armed_reg <= 1'b1;
      end
      if (sw_set) begin
        pend_sw_reg <= 1'b1;
      end else if (tx_start && pend_sw_reg) begin
        pend_sw_reg <= 1'b0;
      end
      if (want_xoff) begin
        pend_xoff_reg <= 1'b1;
      end else if (tx_start && !pend_sw_reg) begin
        pend_xoff_reg <= 1'b0;
      end
      if (want_xon) begin
        pend_xon_reg <= !want_xoff;
      end else if (want_xoff || (tx_start && start_xon)) begin
        pend_xon_reg <= 1'b0;
      end
      if (tx_start) begin
        inflight_sw_reg <= pend_sw_reg;
        tx_ptime_reg <= start_xon ? 16'h0000 : tx_time_reg;
      end
    end
  end

  assign HRDATA = rdata_reg;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign RX_VERDICT = '{decide: decide_reg, drop: drop_reg};
  assign XOFF_RX_EVENT = xoff_evt_reg;
  assign TX_HOLD = hold_reg;
  assign TX_PAUSE = '{req: tx_req_reg, ptime: tx_ptime_reg};
  assign ABOVE_HIGH = above_reg;
  assign BELOW_LOW = below_reg;
endmodule // mpf_flow_ctrl

// [mpf_flow_ctrl_asserts.sv]
// Concurrent checks on the ports of the pause flow-control unit.
`timescale 1ns/1ps
module mpf_flow_ctrl_asserts
  import mpf_pkg::*;
#(
  parameter int unsigned WM_W = 13
) (
  input wire logic SYS_CLK,
  input wire logic RESET_N,
  input wire mpf_pkg::mpf_rx_frame_t RX_FRAME,
  input wire mpf_pkg::mpf_rx_verdict_t RX_VERDICT,
  input wire logic XOFF_RX_EVENT,
  input wire logic TX_BUSY,
  input wire logic TX_HOLD,
  input wire mpf_pkg::mpf_tx_pause_t TX_PAUSE,
  input wire logic TX_PAUSE_DONE,
  input wire logic [WM_W-1:0] RX_FILL,
  input wire logic ABOVE_HIGH,
  input wire logic BELOW_LOW
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!RESET_N);
  property p_bad_fcs;
    RX_FRAME.eof && !RX_FRAME.fcs_ok |=> !RX_VERDICT.decide && !XOFF_RX_EVENT;
  endproperty
  a_bad_fcs: assert property (p_bad_fcs) else $error("action on a bad frame");
  property p_vcause;
    RX_VERDICT.decide |-> $past(RX_FRAME.eof && RX_FRAME.fcs_ok);
  endproperty
  a_vcause: assert property (p_vcause) else $error("verdict without a good frame");
  property p_xcause;
    XOFF_RX_EVENT |-> $past(RX_FRAME.eof) && $past(RX_FRAME.ptime) != 16'h0;
  endproperty
  a_xcause: assert property (p_xcause) else $error("xoff event without xoff frame");
  property p_xop;
    XOFF_RX_EVENT |-> $past(RX_FRAME.opcode) == PAUSE_OPCODE;
  endproperty
  a_xop: assert property (p_xop) else $error("xoff event with wrong opcode");
  property p_hold;
    XOFF_RX_EVENT && !TX_BUSY |=> TX_HOLD;
  endproperty
  a_hold: assert property (p_hold) else $error("transmit not held after xoff");
  property p_req;
    TX_PAUSE.req && !TX_PAUSE_DONE |=> TX_PAUSE.req && $stable(TX_PAUSE.ptime);
  endproperty
  a_req: assert property (p_req) else $error("pause request dropped or changed");
  property p_done;
    TX_PAUSE.req && TX_PAUSE_DONE |=> !TX_PAUSE.req;
  endproperty
  a_done: assert property (p_done) else $error("pause request kept after done");
  property p_below;
    RX_FILL == '0 |=> BELOW_LOW;
  endproperty
  a_below: assert property (p_below) else $error("empty fifo not below low");
  property p_above;
    &RX_FILL |=> ABOVE_HIGH;
  endproperty
  a_above: assert property (p_above) else $error("full fifo not above high");
  c_xoff: cover property (XOFF_RX_EVENT);
  c_sent: cover property (TX_PAUSE.req && TX_PAUSE_DONE);
  c_drop: cover property (RX_VERDICT.decide && RX_VERDICT.drop);
  c_halt: cover property (TX_HOLD && TX_BUSY);
endmodule // mpf_flow_ctrl_asserts
bind mpf_flow_ctrl mpf_flow_ctrl_asserts #(.WM_W(WM_W)) mpf_flow_ctrl_asserts_inst (.SYS_CLK,
  .RESET_N, .RX_FRAME, .RX_VERDICT, .XOFF_RX_EVENT, .TX_BUSY, .TX_HOLD, .TX_PAUSE,
  .TX_PAUSE_DONE, .RX_FILL, .ABOVE_HIGH, .BELOW_LOW);

// [mpf_link_partner.sv]
// Link partner and transmitter model: sends control frames and sends requested pause frames.
`timescale 1ns/1ps
module mpf_link_partner
  import mpf_pkg::*;
(
  input wire logic clk,
  input wire mpf_pkg::mpf_tx_pause_t pause,
  output logic done,
  output mpf_pkg::mpf_rx_frame_t frame
);
  int slow = 0;
  int n_sent = 0;
  int cnt = 0;
  logic [15:0] last_ptime = 16'h0;
  initial begin
    done = 1'b0;
    frame = '0;
  end
  // Outside the end-of-frame cycle every field is inverted so stale values never look valid.
  task automatic send(input logic [47:0] d, input logic [15:0] t, op, pt, input logic ok);
    @(posedge clk);
    frame <= '{1'b1, ok, d, t, op, pt};
    @(posedge clk);
    frame <= '{1'b0, ~ok, ~d, ~t, ~op, ~pt};
  endtask
  // A requested frame goes out after slow extra cycles, then done pulses for one cycle.
  always @(posedge clk) begin
    done <= 1'b0;
    if (pause.req && !done) begin
      cnt <= cnt + 1;
      if (cnt >= slow) begin
        done <= 1'b1;
        cnt <= 0;
        n_sent <= n_sent + 1;
        last_ptime <= pause.ptime;
      end
    end
  end
endmodule // mpf_link_partner

// [test_mpf_flow_ctrl.sv]
// Self-checking testbench of the pause flow-control unit.
`timescale 1ns/1ps
module test_mpf_flow_ctrl;
  import mpf_pkg::*;
  logic SYS_CLK = 1'b0;
  logic RESET_N = 1'b0;
  logic HSEL = 1'b0, HWRITE = 1'b0, RX_OVERFLOW = 1'b0, EXT_XOFF = 1'b0, EXT_RESUME = 1'b0;
  logic TX_BUSY = 1'b0;
  logic [1:0] HTRANS = 2'h0;
  logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
  logic HREADYOUT, HRESP, XOFF_RX_EVENT, TX_HOLD, TX_PAUSE_DONE, ABOVE_HIGH, BELOW_LOW;
  logic [12:0] RX_FILL = 13'h0;
  logic [47:0] STATION_ADDR = 48'h0a0b_0c0d_0e0f;
  localparam logic [47:0] PADDR = 48'h0180_c200_0001;
  mpf_rx_frame_t RX_FRAME;
  mpf_rx_verdict_t RX_VERDICT;
  mpf_tx_pause_t TX_PAUSE;
  int errors = 0, n_compared = 0;
  initial forever #12.5 SYS_CLK = ~SYS_CLK;
  mpf_flow_ctrl #(.SLOT_CNT(2)) mpf_flow_ctrl_inst (.SYS_CLK, .RESET_N, .HSEL, .HADDR, .HTRANS,
    .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP,
    .STATION_ADDR, .RX_FRAME, .RX_VERDICT, .XOFF_RX_EVENT, .TX_BUSY, .TX_HOLD, .TX_PAUSE,
    .TX_PAUSE_DONE, .RX_FILL, .RX_OVERFLOW, .EXT_XOFF, .EXT_RESUME, .ABOVE_HIGH, .BELOW_LOW);
  mpf_link_partner mpf_link_partner_inst (.clk(SYS_CLK), .pause(TX_PAUSE),
    .done(TX_PAUSE_DONE), .frame(RX_FRAME));
  task automatic end_sim();
    $display("Compared %0d, mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdy();
    for (int i = 0; i <= 20; i++) begin
      @(posedge SYS_CLK);
      if (HREADYOUT === 1'b1) return;
    end
    errors++;
    end_sim();
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    HSEL <= 1'b1;
    HTRANS <= HTRANS_NONSEQ;
    HWRITE <= w;
    HADDR <= {24'h0, a};
    rdy();
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    rdy();
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
    bus(1'b0, a, 32'h0);
    chk(HRDATA & m, e);
  endtask
  task automatic fr(input logic [47:0] d, input logic [15:0] t, op, pt, input logic ok);
    mpf_link_partner_inst.send(d, t, op, pt, ok);
  endtask
  task automatic sent(input int n, input logic [15:0] pt);
    int i;
    for (i = 0; i < 80 && mpf_link_partner_inst.n_sent < n; i++) @(posedge SYS_CLK);
    if (i == 80) begin
      errors++;
      end_sim();
    end
    repeat (10) @(posedge SYS_CLK);
    chk(mpf_link_partner_inst.n_sent, n);
    chk(mpf_link_partner_inst.last_ptime, pt);
  endtask
  task automatic resume();
    repeat (4) @(posedge SYS_CLK);
    EXT_RESUME <= 1'b1;
    repeat (4) @(posedge SYS_CLK);
    EXT_RESUME <= 1'b0;
  endtask
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    errors++;
    end_sim();
  end
  initial begin
    repeat (2) @(posedge SYS_CLK);
    RESET_N <= 1'b1;
    rd(ADDR_CTRL, 32'h0);
    rd(8'h28, 32'h0);
    chk(HRESP, 1'b0);
    bus(1'b1, ADDR_PADDR_LO, 32'hc200_0001);
    bus(1'b1, ADDR_PADDR_HI, 32'h0180);
    bus(1'b1, ADDR_CTL_TYPE, 32'h8808);
    bus(1'b1, ADDR_CTRL, 32'h1);
    fr(PADDR, 16'h8808, 16'h1, 16'h3, 1'b1);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_XOFF_CNT, 32'h1);
    repeat (12) @(posedge SYS_CLK);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    fr(PADDR, 16'h8808, 16'h1, 16'hffff, 1'b1);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    fr(PADDR, 16'h8808, 16'h1, 16'h0, 1'b1);
    rd(ADDR_STATUS, 32'h0, 32'h1);
    rd(ADDR_XON_CNT, 32'h1);
    $display("test receive pause done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, {31'h0, i != 3});
      fr(PADDR, i == 2 ? 16'h8809 : 16'h8808, i == 1 ? 16'h2 : 16'h1, 16'h5, i != 0);
      rd(ADDR_XOFF_CNT, 32'h2);
    end
    bus(1'b1, ADDR_CTRL, 32'h1);
    fr(STATION_ADDR, 16'h8808, 16'h1, 16'h1, 1'b1);
    rd(ADDR_XOFF_CNT, 32'h3);
    $display("test receive filter done");
    for (int i = 0; i < 4; i++) begin
      bus(1'b1, ADDR_CTRL, i == 0 ? 32'h5 : (i == 3 ? 32'h9 : 32'h1));
      fr(i < 2 ? STATION_ADDR : PADDR, 16'h8808, i < 2 ? 16'h1 : 16'h2, 16'h1, 1'b1);
      #1 chk(RX_VERDICT, {1'b1, i == 0 || i == 2});
    end
    $display("test host verdict done");
    bus(1'b1, ADDR_CTRL, 32'h1);
    TX_BUSY <= 1'b1;
    fr(PADDR, 16'h8808, 16'h1, 16'hffff, 1'b1);
    #1 chk(XOFF_RX_EVENT, 1'b1);
    repeat (3) @(posedge SYS_CLK);
    chk(TX_HOLD, 1'b0);
    TX_BUSY <= 1'b0;
    repeat (3) @(posedge SYS_CLK);
    chk(TX_HOLD, 1'b1);
    fr(PADDR, 16'h8808, 16'h1, 16'h0, 1'b1);
    repeat (2) @(posedge SYS_CLK);
    chk(TX_HOLD, 1'b0);
    bus(1'b1, ADDR_CTRL, 32'h81);
    TX_BUSY <= 1'b1;
    fr(PADDR, 16'h8808, 16'h1, 16'hffff, 1'b1);
    repeat (2) @(posedge SYS_CLK);
    chk(TX_HOLD, 1'b1);
    fr(PADDR, 16'h8808, 16'h1, 16'h0, 1'b1);
    TX_BUSY <= 1'b0;
    $display("test transmit hold done");
    bus(1'b1, ADDR_TX_TIME, 32'h0123);
    bus(1'b1, ADDR_HIGH_WM, 32'h64);
    bus(1'b1, ADDR_LOW_WM, 32'ha);
    bus(1'b1, ADDR_CTRL, 32'h0);
    RX_FILL <= 13'h1fff;
    sent(0, 16'h0);
    RX_FILL <= 13'h5;
    bus(1'b1, ADDR_CTRL, 32'h2);
    sent(0, 16'h0);
    RX_FILL <= 13'h1fff;
    sent(1, 16'h0123);
    chk({ABOVE_HIGH, BELOW_LOW}, 2'b10);
    mpf_link_partner_inst.slow = 6;
    for (int i = 0; i < 2; i++) begin
      RX_OVERFLOW <= 1'b1;
      @(posedge SYS_CLK);
      RX_OVERFLOW <= 1'b0;
      sent(2, 16'h0123);
    end
    bus(1'b1, ADDR_CTRL, 32'h12);
    RX_FILL <= 13'h5;
    sent(3, 16'h0);
    rd(ADDR_STATUS, 32'h4, 32'h6);
    chk({ABOVE_HIGH, BELOW_LOW}, 2'b01);
    $display("test automatic pause done");
    bus(1'b1, ADDR_CTRL, 32'h40);
    sent(4, 16'h0123);
    rd(ADDR_CTRL, 32'h0);
    bus(1'b1, ADDR_TX_TIME, 32'h0);
    bus(1'b1, ADDR_CTRL, 32'h40);
    sent(5, 16'h0);
    bus(1'b1, ADDR_TX_TIME, 32'h0123);
    $display("test software pause done");
    bus(1'b1, ADDR_CTRL, 32'h32);
    EXT_XOFF <= 1'b1;
    sent(6, 16'h0123);
    EXT_XOFF <= 1'b0;
    resume();
    sent(7, 16'h0);
    bus(1'b1, ADDR_CTRL, 32'h30);
    EXT_XOFF <= 1'b1;
    sent(7, 16'h0);
    $display("test external pins done");
    end_sim();
  end
endmodule // test_mpf_flow_ctrl
